// >>> design/ace_consts.vh
// constants for the comparator event logic
`ifndef ACE_CONSTS_VH
`define ACE_CONSTS_VH

// register byte offsets
`define ACE_OFF_CSR        4'h0
`define ACE_OFF_BITOP      4'h4
`define ACE_OFF_INT_STAT   4'h8
`define ACE_OFF_INT_MASK   4'hC

// control/status field positions
`define ACE_CSR_POWER_OFF  7
`define ACE_CSR_RSVD       6
`define ACE_CSR_RESULT     5
`define ACE_CSR_FLAG       4
`define ACE_CSR_IRQ_EN     3
`define ACE_CSR_ROUTE      2
`define ACE_CSR_SEL_HI     1
`define ACE_CSR_SEL_LO     0

// bit operation field positions
`define ACE_BITOP_VALUE    3
`define ACE_BITOP_IDX_HI   2

// interrupt status field positions
`define ACE_INT_EVENT      0
`define ACE_INT_RISE       1
`define ACE_INT_FALL       2
`define ACE_INT_W          3

// reset values
`define ACE_CSR_RESET      8'h00
`define ACE_PWR_RESET      1'h0
`define ACE_SEL_RESET      2'h0
`define ACE_INT_RESET      3'h0

// event select codes
`define ACE_SEL_TOGGLE     2'h0
`define ACE_SEL_RSVD       2'h1
`define ACE_SEL_FALL       2'h2
`define ACE_SEL_RISE       2'h3

// axi responses
`define ACE_RESP_OKAY      2'h0
`define ACE_RESP_SLVERR    2'h2

`endif

// >>> design/ace_sync_edge.v
// comparator result synchroniser with edge detection
`timescale 1ns/1ns
module ace_sync_edge (
    input  wire i_core_clk,
    input  wire i_nrst,
    input  wire i_raw,
    input  wire i_hold,
    output wire o_level,
    output wire o_rise,
    output wire o_fall
);

    reg meta_r;
    reg sync_r;
    reg prev_r;

    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= i_raw;
            sync_r <= meta_r;
        end
    end

    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            prev_r <= 1'b0;
        end else if (!i_hold) begin
            prev_r <= sync_r;
        end
    end

    // frozen while powered off
    assign o_level = prev_r;
    assign o_rise  = !i_hold && sync_r && !prev_r;
    assign o_fall  = !i_hold && !sync_r && prev_r;

endmodule // ace_sync_edge

// >>> design/ace_core.v
// comparator control/status, event flag, interrupts and axi4-lite slave
//
// Contract
// - result bit reads one while positive input exceeds negative input
// - power-off bit 7 switches the comparator off at any time
// - bit 6 is reserved and always reads zero
// - bit 5 shows the comparator result, read only
// - event flag bit 4 sets on a result change matching the select field
// - interrupt request while flag, enable and global enable all set
// - flag clears when the comparator vector is executed
// - writing one to flag clears it, zero leaves it
// - single-bit set or clear on other bits also clears a set flag
// - interrupt enable bit 3 blocks requests while zero
// - route bit 2 drives result into capture front end, else no connection
// - select 00 toggle, 01 reserved, 10 falling, 11 rising
`timescale 1ns/1ns
`include "ace_consts.vh"
module ace_core (
    input  wire        i_core_clk,
    input  wire        i_nrst,
    // axi4-lite write address
    input  wire [3:0]  i_s_axi_awaddr,
    input  wire        i_s_axi_awvalid,
    output wire        o_s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] i_s_axi_wdata,
    input  wire [3:0]  i_s_axi_wstrb,
    input  wire        i_s_axi_wvalid,
    output wire        o_s_axi_wready,
    // axi4-lite write response
    output wire [1:0]  o_s_axi_bresp,
    output wire        o_s_axi_bvalid,
    input  wire        i_s_axi_bready,
    // axi4-lite read address
    input  wire [3:0]  i_s_axi_araddr,
    input  wire        i_s_axi_arvalid,
    output wire        o_s_axi_arready,
    // axi4-lite read data
    output wire [31:0] o_s_axi_rdata,
    output wire [1:0]  o_s_axi_rresp,
    output wire        o_s_axi_rvalid,
    input  wire        i_s_axi_rready,
    // comparator and cpu side
    input  wire        i_comparator_result,
    input  wire        i_global_irq_enable,
    input  wire        i_vector_taken,
    output wire        o_comparator_power_off,
    output wire        o_comparator_irq,
    output wire        o_capture_source,
    output wire        o_int
);

    // register selects
    localparam SEL_NONE  = 3'h0;
    localparam SEL_CSR   = 3'h1;
    localparam SEL_BITOP = 3'h2;
    localparam SEL_STAT  = 3'h3;
    localparam SEL_MASK  = 3'h4;

    function [2:0] addr_sel;
        input [3:0] addr;
        begin
            case (addr)
                `ACE_OFF_CSR:      addr_sel = SEL_CSR;
                `ACE_OFF_BITOP:    addr_sel = SEL_BITOP;
                `ACE_OFF_INT_STAT: addr_sel = SEL_STAT;
                `ACE_OFF_INT_MASK: addr_sel = SEL_MASK;
                default:           addr_sel = SEL_NONE;
            endcase
        end
    endfunction

    // bus state
    reg                  awready_r;
    reg                  wready_r;
    reg                  bvalid_r;
    reg  [1:0]           bresp_r;
    reg                  arready_r;
    reg                  rvalid_r;
    reg  [1:0]           rresp_r;
    reg  [31:0]          rdata_r;
    reg  [3:0]           waddr_r;
    reg  [31:0]          wdata_r;
    reg  [3:0]           wstrb_r;

    // control/status state
    reg                  power_off_r;
    reg                  irq_en_r;
    reg                  route_r;
    reg  [1:0]           evt_sel_r;
    reg                  flag_r;
    reg  [`ACE_INT_W-1:0] int_stat_r;
    reg  [`ACE_INT_W-1:0] int_mask_r;

    // output flops
    reg                  cmp_irq_r;
    reg                  capture_r;
    reg                  int_r;

    // combinational
    reg                  csr_wr_en;
    reg  [7:0]           csr_wr_val;
    reg                  stat_wr_en;
    reg                  mask_wr_en;
    reg                  wr_err;
    reg  [31:0]          rd_val;
    reg                  rd_err;
    reg  [7:0]           bitop_val;
    reg                  evt_hit;
    reg                  flag_nxt;
    reg  [`ACE_INT_W-1:0] stat_nxt;

    wire                 result;
    wire                 res_rise;
    wire                 res_fall;
    wire [7:0]           csr_read;
    wire                 aw_hs;
    wire                 w_hs;
    wire                 b_hs;
    wire                 ar_hs;
    wire                 r_hs;
    wire                 wr_go;
    wire [2:0]           wr_sel;
    wire [2:0]           rd_sel;

    ace_sync_edge u_sync (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_raw      (i_comparator_result),
        .i_hold     (power_off_r),
        .o_level    (result),
        .o_rise     (res_rise),
        .o_fall     (res_fall)
    );

    assign csr_read = {power_off_r, 1'b0, result, flag_r, irq_en_r, route_r, evt_sel_r};

    assign aw_hs  = i_s_axi_awvalid && awready_r;
    assign w_hs   = i_s_axi_wvalid && wready_r;
    assign b_hs   = bvalid_r && i_s_axi_bready;
    assign ar_hs  = i_s_axi_arvalid && arready_r;
    assign r_hs   = rvalid_r && i_s_axi_rready;
    assign wr_go  = !awready_r && !wready_r && !bvalid_r;
    assign wr_sel = addr_sel(waddr_r);
    assign rd_sel = addr_sel(i_s_axi_araddr);

    // write decode
    always @* begin
        csr_wr_en  = 1'b0;
        csr_wr_val = csr_read;
        stat_wr_en = 1'b0;
        mask_wr_en = 1'b0;
        wr_err     = 1'b0;
        bitop_val  = csr_read;
        bitop_val[wdata_r[`ACE_BITOP_IDX_HI:0]] = wdata_r[`ACE_BITOP_VALUE];
        if (wr_go) begin
            case (wr_sel)
                SEL_CSR: begin
                    csr_wr_en  = wstrb_r[0];
                    csr_wr_val = wdata_r[7:0];
                end
                SEL_BITOP: begin
                    csr_wr_en  = wstrb_r[0];
                    csr_wr_val = bitop_val;
                end
                SEL_STAT: begin
                    stat_wr_en = wstrb_r[0];
                end
                SEL_MASK: begin
                    mask_wr_en = wstrb_r[0];
                end
                default: begin
                    wr_err = 1'b1;
                end
            endcase
        end
    end

    // read decode
    always @* begin
        rd_val = 32'h00000000;
        rd_err = 1'b0;
        case (rd_sel)
            SEL_CSR: begin
                rd_val[7:0] = csr_read;
            end
            SEL_BITOP: begin
                rd_val = 32'h00000000;
            end
            SEL_STAT: begin
                rd_val[`ACE_INT_W-1:0] = int_stat_r;
            end
            SEL_MASK: begin
                rd_val[`ACE_INT_W-1:0] = int_mask_r;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    // event match and flag next value
    always @* begin
        case (evt_sel_r)
            `ACE_SEL_TOGGLE: evt_hit = res_rise || res_fall;
            `ACE_SEL_FALL:   evt_hit = res_fall;
            `ACE_SEL_RISE:   evt_hit = res_rise;
            default:         evt_hit = 1'b0;
        endcase
        flag_nxt = flag_r;
        if (i_vector_taken) begin
            flag_nxt = 1'b0;
        end
        if (csr_wr_en && csr_wr_val[`ACE_CSR_FLAG]) begin
            flag_nxt = 1'b0;
        end
        if (evt_hit) begin
            flag_nxt = 1'b1;
        end
    end

    // interrupt status next value
    always @* begin
        stat_nxt = int_stat_r;
        if (stat_wr_en) begin
            stat_nxt = int_stat_r & ~wdata_r[`ACE_INT_W-1:0];
        end
        stat_nxt[`ACE_INT_EVENT] = stat_nxt[`ACE_INT_EVENT] | evt_hit;
        stat_nxt[`ACE_INT_RISE]  = stat_nxt[`ACE_INT_RISE] | res_rise;
        stat_nxt[`ACE_INT_FALL]  = stat_nxt[`ACE_INT_FALL] | res_fall;
    end

    // write channels
    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= `ACE_RESP_OKAY;
            waddr_r   <= 4'h0;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
        end else begin
            if (aw_hs) begin
                awready_r <= 1'b0;
                waddr_r   <= i_s_axi_awaddr;
            end
            if (w_hs) begin
                wready_r <= 1'b0;
                wdata_r  <= i_s_axi_wdata;
                wstrb_r  <= i_s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_err ? `ACE_RESP_SLVERR : `ACE_RESP_OKAY;
            end
            if (b_hs) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // read channels
    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= `ACE_RESP_OKAY;
            rdata_r   <= 32'h00000000;
        end else begin
            if (ar_hs) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_val;
                rresp_r   <= rd_err ? `ACE_RESP_SLVERR : `ACE_RESP_OKAY;
            end
            if (r_hs) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // control/status fields
    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            power_off_r <= `ACE_PWR_RESET;
            irq_en_r    <= 1'b0;
            route_r     <= 1'b0;
            evt_sel_r   <= `ACE_SEL_RESET;
            flag_r      <= 1'b0;
        end else begin
            if (csr_wr_en) begin
                power_off_r <= csr_wr_val[`ACE_CSR_POWER_OFF];
                irq_en_r    <= csr_wr_val[`ACE_CSR_IRQ_EN];
                route_r     <= csr_wr_val[`ACE_CSR_ROUTE];
                evt_sel_r   <= csr_wr_val[`ACE_CSR_SEL_HI:`ACE_CSR_SEL_LO];
            end
            flag_r <= flag_nxt;
        end
    end

    // interrupt status and mask
    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            int_stat_r <= `ACE_INT_RESET;
            int_mask_r <= `ACE_INT_RESET;
        end else begin
            int_stat_r <= stat_nxt;
            if (mask_wr_en) begin
                int_mask_r <= wdata_r[`ACE_INT_W-1:0];
            end
        end
    end

    // registered outputs
    always @(posedge i_core_clk) begin
        if (!i_nrst) begin
            cmp_irq_r <= 1'b0;
            capture_r <= 1'b0;
            int_r     <= 1'b0;
        end else begin
            cmp_irq_r <= flag_r && irq_en_r && i_global_irq_enable;
            capture_r <= route_r && result;
            int_r     <= |(int_stat_r & int_mask_r);
        end
    end

    assign o_comparator_power_off = power_off_r;
    assign o_comparator_irq       = cmp_irq_r;
    assign o_capture_source       = capture_r;
    assign o_int                  = int_r;
    assign o_s_axi_awready        = awready_r;
    assign o_s_axi_wready         = wready_r;
    assign o_s_axi_bvalid         = bvalid_r;
    assign o_s_axi_bresp          = bresp_r;
    assign o_s_axi_arready        = arready_r;
    assign o_s_axi_rvalid         = rvalid_r;
    assign o_s_axi_rresp          = rresp_r;
    assign o_s_axi_rdata          = rdata_r;

endmodule // ace_core

// >>> bench/ace_core_assertions.sv
// checker for the comparator event logic ports
`timescale 1ns/1ns
module ace_core_assertions (
    input wire        i_core_clk,
    input wire        i_nrst,
    input wire [3:0]  i_s_axi_awaddr,
    input wire        i_s_axi_awvalid,
    input wire        o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire        i_s_axi_wvalid,
    input wire        o_s_axi_wready,
    input wire [1:0]  o_s_axi_bresp,
    input wire        o_s_axi_bvalid,
    input wire        i_s_axi_arvalid,
    input wire        o_s_axi_arready,
    input wire [31:0] o_s_axi_rdata,
    input wire        o_s_axi_rvalid,
    input wire        i_global_irq_enable,
    input wire        i_vector_taken,
    input wire        o_comparator_power_off,
    input wire        o_comparator_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_wr_taken;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    sequence s_csr_wr;
        s_wr_taken ##0 (i_s_axi_awaddr == 4'h0);
    endsequence
    property p_bresp_time; s_wr_taken |-> ##2 o_s_axi_bvalid; endproperty
    a_bresp_time: assert property (p_bresp_time) else $error("write response late");
    property p_slverr; s_wr_taken ##0 (i_s_axi_awaddr[1:0] != 2'h0) |-> ##2 o_s_axi_bresp == 2'h2; endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
    property p_ar_time; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready; endproperty
    a_ar_time: assert property (p_ar_time) else $error("read answer late");
    property p_rsvd; o_s_axi_rvalid |-> !o_s_axi_rdata[6] && o_s_axi_rdata[31:8] == 24'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_power; s_csr_wr |-> ##3 o_comparator_power_off == $past(i_s_axi_wdata[7], 3); endproperty
    a_power: assert property (p_power) else $error("power off bit not applied");
    property p_irq_en; s_csr_wr ##0 !i_s_axi_wdata[3] |-> ##4 !o_comparator_irq; endproperty
    a_irq_en: assert property (p_irq_en) else $error("request with enable low");
    property p_gie; !i_global_irq_enable |=> !o_comparator_irq; endproperty
    a_gie: assert property (p_gie) else $error("request with global enable low");
    property p_vector; i_vector_taken |-> ##2 !o_comparator_irq; endproperty
    a_vector: assert property (p_vector) else $error("flag kept after vector");
endmodule // ace_core_assertions

bind ace_core ace_core_assertions i_chk (.*);

// >>> bench/ace_cpu_model.sv
// cpu interrupt acknowledge and capture unit model
`timescale 1ns/1ns
module ace_cpu_model (
    input  wire        i_core_clk,
    input  wire        i_irq,
    input  wire        i_auto_ack,
    input  wire        i_capture,
    input  wire        i_capture_irq_en,
    output logic       o_vector_taken,
    output logic [7:0] o_capture_cnt
);
    logic [1:0] hold_r;
    logic       cap_r;
    initial begin
        o_vector_taken = 1'b0;
        o_capture_cnt = 8'h00;
        hold_r = 2'h0;
        cap_r = 1'b0;
    end
    always @(posedge i_core_clk) begin
        o_vector_taken <= i_auto_ack && i_irq && hold_r == 2'h0;
        hold_r <= (i_auto_ack && i_irq && hold_r == 2'h0) ? 2'h3 : (hold_r == 2'h0 ? 2'h0 : hold_r - 2'h1);
        cap_r <= i_capture;
        if (i_capture_irq_en && i_capture && !cap_r) o_capture_cnt <= o_capture_cnt + 8'h01;
    end
endmodule // ace_cpu_model

// >>> bench/ace_core_tb_top.sv
// testbench for the comparator event logic
`timescale 1ns/1ns
module ace_core_tb_top;
    logic        clk, nrst, awv, wv, bready, arv, rready, comp, gie, auto, cap_en;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd_d;
    logic [1:0]  bresp, rresp, rsp;
    logic        awrdy, wrdy, bv, arrdy, rv, vec, pwr, irq, capsrc, intr;
    logic [7:0]  ccnt;
    integer      error_cnt = 0;
    integer      tests_run = 0;
    ace_core i_ace_core (.i_core_clk(clk), .i_nrst(nrst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv),
        .o_s_axi_awready(awrdy), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wv),
        .o_s_axi_wready(wrdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv), .o_s_axi_arready(arrdy), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rready), .i_comparator_result(comp),
        .i_global_irq_enable(gie), .i_vector_taken(vec), .o_comparator_power_off(pwr),
        .o_comparator_irq(irq), .o_capture_source(capsrc), .o_int(intr));
    ace_cpu_model i_ace_cpu_model (.i_core_clk(clk), .i_irq(irq), .i_auto_ack(auto), .i_capture(capsrc),
        .i_capture_irq_en(cap_en), .o_vector_taken(vec), .o_capture_cnt(ccnt));
    task results;
        if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task tmo;
        error_cnt++;
        $display("[FAIL] %0t bus timeout", $time);
        results;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            bready <= 1'b1;
            for (n = 0; n < 50 && (awv || wv); n++) begin
                @(posedge clk);
                if (awrdy) awv <= 1'b0;
                if (wrdy) wv <= 1'b0;
            end
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (bv !== 1'b1 && n < 50);
            if (bv !== 1'b1) tmo;
            rsp = bresp;
            bready <= 1'b0;
        end
    endtask
    task rd(input logic [3:0] a);
        integer n;
        begin
            @(posedge clk);
            araddr <= a;
            arv <= 1'b1;
            rready <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
                if (arrdy) arv <= 1'b0;
            end while (rv !== 1'b1 && n < 50);
            if (rv !== 1'b1) tmo;
            rd_d = rdata;
            rsp = rresp;
            rready <= 1'b0;
        end
    endtask
    task rc(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_d, e);
    endtask
    task st;
        repeat (8) @(posedge clk);
    endtask
    task sc_reset;
        begin
            rc(4'h0, 32'h0);
            rc(4'h8, 32'h0);
            rc(4'hC, 32'h0);
            rd(4'h2);
            chk({30'h0, rsp}, 32'h2);
            wr(4'h2, 32'hFF);
            chk({30'h0, rsp}, 32'h2);
        end
    endtask
    task sc_sel;
        integer s;
        logic [31:0] sv;
        begin
            for (s = 0; s < 4; s++) begin
                sv = s;
                wr(4'h0, 32'h10 | sv);
                comp <= 1'b1;
                st;
                rc(4'h0, 32'h20 | sv | ((s == 0 || s == 3) ? 32'h10 : 32'h0));
                wr(4'h0, 32'h10 | sv);
                comp <= 1'b0;
                st;
                rc(4'h0, sv | ((s == 0 || s == 2) ? 32'h10 : 32'h0));
            end
            wr(4'h0, 32'h0);
            comp <= 1'b1;
            st;
            wr(4'h0, 32'h0);
            rc(4'h0, 32'h30);
            wr(4'h0, 32'h10);
            rc(4'h0, 32'h20);
        end
    endtask
    task sc_int;
        begin
            rc(4'h8, 32'h7);
            chk({31'h0, intr}, 32'h0);
            wr(4'hC, 32'h1);
            repeat (2) @(posedge clk);
            chk({31'h0, intr}, 32'h1);
            rc(4'hC, 32'h1);
            wr(4'h8, 32'h7);
            rc(4'h8, 32'h0);
            chk({31'h0, intr}, 32'h0);
        end
    endtask
    task sc_irq;
        begin
            gie <= 1'b1;
            wr(4'h0, 32'h08);
            comp <= 1'b0;
            st;
            chk({31'h0, irq}, 32'h1);
            gie <= 1'b0;
            repeat (3) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
            gie <= 1'b1;
            repeat (3) @(posedge clk);
            chk({31'h0, irq}, 32'h1);
            wr(4'h0, 32'h00);
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
            rc(4'h0, 32'h10);
            auto <= 1'b1;
            wr(4'h0, 32'h08);
            st;
            chk({31'h0, irq}, 32'h0);
            rc(4'h0, 32'h08);
            auto <= 1'b0;
            wr(4'h0, 32'h00);
        end
    endtask
    task sc_route;
        begin
            cap_en <= 1'b1;
            comp <= 1'b1;
            st;
            chk({31'h0, capsrc}, 32'h0);
            wr(4'h4, 32'hA);
            rc(4'h0, 32'h24);
            chk({31'h0, capsrc}, 32'h1);
            chk({24'h0, ccnt}, 32'h1);
            wr(4'h4, 32'h2);
            rc(4'h0, 32'h20);
            chk({31'h0, capsrc}, 32'h0);
        end
    endtask
    task sc_power;
        begin
            wr(4'h0, 32'h80);
            comp <= 1'b0;
            st;
            rc(4'h0, 32'hA0);
            chk({31'h0, pwr}, 32'h1);
            wr(4'h0, 32'h00);
            chk({31'h0, pwr}, 32'h0);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {nrst, awv, wv, bready, arv, rready, comp, gie, auto, cap_en} = 10'h0;
        {awaddr, araddr, wdata} = 40'h0;
        wstrb = 4'hF;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        sc_reset;
        sc_sel;
        sc_int;
        sc_irq;
        sc_route;
        sc_power;
        results;
    end
endmodule // ace_core_tb_top
